// >>> hw/acw_pkg.sv
// shared constants, types and helpers for the analog compare and watchdog block
package acw_pkg;

   typedef logic signed [15:0] acw_val_t;
   typedef logic signed [31:0] acw_wide_t;
   typedef enum {WD_IDLE, WD_ARMED} acw_wd_state_t;

   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_GAIN   = 8'h04;
   localparam logic [7:0] REG_OFFSET = 8'h08;
   localparam logic [7:0] REG_ON     = 8'h0C;
   localparam logic [7:0] REG_OFF    = 8'h10;
   localparam logic [7:0] REG_DEC    = 8'h14;
   localparam logic [7:0] REG_UPPER  = 8'h18;
   localparam logic [7:0] REG_LOWER  = 8'h1C;
   localparam logic [7:0] REG_SRC    = 8'h20;
   localparam logic [7:0] REG_DELAY  = 8'h24;
   localparam logic [7:0] REG_SCAN   = 8'h28;
   localparam logic [7:0] REG_STATUS = 8'h2C;
   localparam logic [7:0] REG_DIFF   = 8'h30;
   localparam logic [7:0] REG_REF    = 8'h34;

   // control bit positions
   localparam int CTRL_ON_BLK  = 0;
   localparam int CTRL_OFF_BLK = 1;
   localparam int CTRL_RETAIN  = 2;
   localparam int CTRL_DLY_EN  = 3;
   localparam int CTRL_W       = 4;

   // source field positions, 2 bits each, block indices 4 bits each
   localparam int SRC_FIRST_LSB  = 0;
   localparam int SRC_SECOND_LSB = 2;
   localparam int SRC_WATCH_LSB  = 4;
   localparam int BLK_FIRST_LSB  = 8;
   localparam int BLK_SECOND_LSB = 12;
   localparam int BLK_WATCH_LSB  = 16;
   localparam int BLK_ON_LSB     = 20;
   localparam int BLK_OFF_LSB    = 24;
   localparam int SRC_W          = 28;

   // source codes
   localparam logic [1:0] SRC_INPUT  = 2'h0;
   localparam logic [1:0] SRC_FLAG   = 2'h1;
   localparam logic [1:0] SRC_OUTPUT = 2'h2;
   localparam logic [1:0] SRC_BLOCK  = 2'h3;

   // ranges and scaling
   localparam acw_wide_t GAIN_MAX   = 32'sh0000_03E8;
   localparam acw_wide_t GAIN_DIV   = 32'sh0000_0064;
   localparam acw_wide_t OFFS_MAX   = 32'sh0000_2710;
   localparam acw_wide_t THR_MAX    = 32'sh0000_4E20;
   localparam acw_wide_t ANA_FULL   = 32'sh0000_03E8;
   localparam acw_wide_t ZERO_W     = 32'sh0000_0000;

   // reset values
   localparam acw_val_t    GAIN_RST  = 16'h0064;
   localparam logic [15:0] SCAN_RST  = 16'h03E8;
   localparam logic [15:0] DELAY_RST = 16'h0000;

   // clamp a bus word into a signed range
   function automatic acw_val_t acw_clip(acw_wide_t v, acw_wide_t lo, acw_wide_t hi);
      acw_wide_t r;
      r = v;
      if (v < lo)
      begin
         r = lo;
      end
      if (v > hi)
      begin
         r = hi;
      end
      return acw_val_t'(r);
   endfunction

   // gain in hundredths, then offset
   function automatic acw_wide_t acw_scale(acw_val_t x, acw_val_t gain, acw_val_t offs);
      acw_wide_t p;
      p = (acw_wide_t'(x) * acw_wide_t'(gain)) / GAIN_DIV;
      return p + acw_wide_t'(offs);
   endfunction

endpackage

// >>> hw/acw_top.sv
// difference comparator with on-delay and deviation watchdog, register port
`timescale 1ns/10ps

// How it works
// - scale each operand: times gain plus offset
// - gain clamped to ten, offset ten thousand
// - difference is first minus second scaled value
// - on>=off: set above on, clear at off
// - on<off: set when on<=diff<off
// - threshold registers clamped to plus minus twenty thousand, block thresholds not
// - decimals stored only, never used in compare
// - thresholds fixed or taken from block value
// - analog input held to zero..one thousand
// - optional on-delay behind comparator output
// - enable rising edge captures watchdog reference
// - band is reference minus lower to plus upper
// - deviations clamped to zero..twenty thousand
// - retentive option keeps reference over power loss
// - scale live and reference alike
// - set outside band while enabled, else cleared
module acw_top #(
   parameter int NBLK = 8
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [7:0]       addr,
   input  wire logic [31:0]      wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [31:0]      rdata,
   input  wire logic [9:0]       analog_input_source,
   input  wire acw_pkg::acw_val_t analog_flag_source,
   input  wire acw_pkg::acw_val_t analog_output_source,
   input  wire acw_pkg::acw_val_t block_value [NBLK],
   input  wire logic             wd_enable,
   input  wire logic             power_loss,
   output logic                  scan_tick,
   output logic                  cmp_q,
   output logic                  cmp_delayed_q,
   output logic                  wd_q
);
   import acw_pkg::*;

   // largest value the 16-bit operand type can carry
   localparam acw_wide_t VAL_MAX = 32'sh0000_7FFF;

   // block count and package ranges must suit the datapath
   generate
      if (NBLK < 1 || NBLK > 16)
      begin : g_chk
         $error("acw_top: NBLK must be 1 to 16");
      end
      if (THR_MAX > VAL_MAX || OFFS_MAX > VAL_MAX || ANA_FULL > VAL_MAX)
      begin : g_rng
         $error("acw_top: ranges exceed the operand width");
      end
      if (GAIN_DIV < 32'sh0000_0001 || acw_wide_t'(GAIN_RST) > GAIN_MAX)
      begin : g_gain
         $error("acw_top: gain divisor or reset gain out of range");
      end
      if (SCAN_RST < 16'h0002)
      begin : g_scan
         $error("acw_top: scan period below two cycles");
      end
      if (CTRL_DLY_EN >= CTRL_W || BLK_OFF_LSB + 4 > SRC_W)
      begin : g_fld
         $error("acw_top: control or source field out of its register");
      end
   endgenerate

   logic [CTRL_W-1:0] ctrl_q;
   acw_val_t          gain_q;
   acw_val_t          offset_q;
   acw_val_t          on_q;
   acw_val_t          off_q;
   logic [1:0]        dec_q;
   acw_val_t          upper_q;
   acw_val_t          lower_q;
   logic [SRC_W-1:0]  src_q;
   logic [15:0]       delay_q;
   logic [15:0]       scan_q;
   logic [15:0]       scan_cnt_q;
   logic              tick_q;
   logic              cmp_q_q;
   logic              dly_q;
   logic [15:0]       hi_cnt_q;
   logic [31:0]       rdata_q;
   acw_wide_t         diff_q;

   acw_val_t          first_op;
   acw_val_t          second_op;
   acw_val_t          watch_op;
   acw_val_t          on_thr;
   acw_val_t          off_thr;
   acw_wide_t         first_act;
   acw_wide_t         second_act;
   acw_wide_t         diff;
   logic              cmp_d;
   acw_wide_t         wr_val;

   acw_wd_if wd ();

   // block value by index, out of range reads block zero
   function automatic acw_val_t blk_pick(logic [3:0] idx);
      acw_val_t r;
      r = block_value[0];
      for (int i = 0; i < NBLK; i++)
      begin
         if (idx == 4'(i))
         begin
            r = block_value[i];
         end
      end
      return r;
   endfunction

   // operand source mux
   function automatic acw_val_t src_pick(logic [1:0] sel, logic [3:0] idx);
      acw_val_t  r;
      acw_wide_t ai;
      ai = acw_wide_t'({22'h000000, analog_input_source});
      case (sel)
         SRC_INPUT:  r = acw_clip(ai, ZERO_W, ANA_FULL);
         SRC_FLAG:   r = analog_flag_source;
         SRC_OUTPUT: r = analog_output_source;
         SRC_BLOCK:  r = blk_pick(idx);
         default:    r = 16'h0000;
      endcase
      return r;
   endfunction

   // scan tick generator
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scan_cnt_q <= 16'h0000;
         tick_q     <= 1'b0;
      end
      else if (scan_cnt_q >= scan_q - 16'h0001)
      begin
         scan_cnt_q <= 16'h0000;
         tick_q     <= 1'b1;
      end
      else
      begin
         scan_cnt_q <= scan_cnt_q + 16'h0001;
         tick_q     <= 1'b0;
      end
   end

   assign wr_val = acw_wide_t'(wdata);

   // register writes with range clamping
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q   <= '0;
         gain_q   <= GAIN_RST;
         offset_q <= 16'h0000;
         on_q     <= 16'h0000;
         off_q    <= 16'h0000;
         dec_q    <= 2'h0;
         upper_q  <= 16'h0000;
         lower_q  <= 16'h0000;
         src_q    <= '0;
         delay_q  <= DELAY_RST;
         scan_q   <= SCAN_RST;
      end
      else if (wr)
      begin
         case (addr)
            REG_CTRL:   ctrl_q   <= wdata[CTRL_W-1:0];
            REG_GAIN:   gain_q   <= acw_clip(wr_val, -GAIN_MAX, GAIN_MAX);
            REG_OFFSET: offset_q <= acw_clip(wr_val, -OFFS_MAX, OFFS_MAX);
            REG_ON:     on_q     <= acw_clip(wr_val, -THR_MAX, THR_MAX);
            REG_OFF:    off_q    <= acw_clip(wr_val, -THR_MAX, THR_MAX);
            REG_DEC:    dec_q    <= wdata[1:0];
            REG_UPPER:  upper_q  <= acw_clip(wr_val, ZERO_W, THR_MAX);
            REG_LOWER:  lower_q  <= acw_clip(wr_val, ZERO_W, THR_MAX);
            REG_SRC:    src_q    <= wdata[SRC_W-1:0];
            REG_DELAY:  delay_q  <= wdata[15:0];
            REG_SCAN:
            begin
               if (wdata[15:0] != 16'h0000)
               begin
                  scan_q <= wdata[15:0];
               end
            end
            default:
            begin
               scan_q <= scan_q;
            end
         endcase
      end
   end

   // operand and threshold selection, scaling, difference
   always_comb
   begin
      first_op   = src_pick(src_q[SRC_FIRST_LSB +: 2], src_q[BLK_FIRST_LSB +: 4]);
      second_op  = src_pick(src_q[SRC_SECOND_LSB +: 2], src_q[BLK_SECOND_LSB +: 4]);
      watch_op   = src_pick(src_q[SRC_WATCH_LSB +: 2], src_q[BLK_WATCH_LSB +: 4]);
      on_thr     = ctrl_q[CTRL_ON_BLK] ? blk_pick(src_q[BLK_ON_LSB +: 4]) : on_q;
      off_thr    = ctrl_q[CTRL_OFF_BLK] ? blk_pick(src_q[BLK_OFF_LSB +: 4]) : off_q;
      first_act  = acw_scale(first_op, gain_q, offset_q);
      second_act = acw_scale(second_op, gain_q, offset_q);
      diff       = first_act - second_act;
   end

   // threshold decision on raw integers
   always_comb
   begin
      cmp_d = cmp_q_q;
      if (on_thr >= off_thr)
      begin
         if (diff > acw_wide_t'(on_thr))
         begin
            cmp_d = 1'b1;
         end
         else if (diff <= acw_wide_t'(off_thr))
         begin
            cmp_d = 1'b0;
         end
         else
         begin
            cmp_d = cmp_q_q;
         end
      end
      else
      begin
         cmp_d = (diff >= acw_wide_t'(on_thr)) &&
                 (diff < acw_wide_t'(off_thr));
      end
   end

   // comparator output, updated on the scan tick
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmp_q_q <= 1'b0;
         diff_q  <= '0;
      end
      else if (tick_q)
      begin
         cmp_q_q <= cmp_d;
         diff_q  <= diff;
      end
   end

   // on-delay: high only after more than delay scans of high input
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hi_cnt_q <= 16'h0000;
         dly_q    <= 1'b0;
      end
      else if (tick_q)
      begin
         if (!ctrl_q[CTRL_DLY_EN])
         begin
            hi_cnt_q <= 16'h0000;
            dly_q    <= cmp_q_q;
         end
         else if (!cmp_q_q)
         begin
            hi_cnt_q <= 16'h0000;
            dly_q    <= 1'b0;
         end
         else
         begin
            if (hi_cnt_q != 16'hFFFF)
            begin
               hi_cnt_q <= hi_cnt_q + 16'h0001;
            end
            dly_q <= (hi_cnt_q >= delay_q);
         end
      end
   end

   // watchdog hookup
   assign wd.scan       = tick_q;
   assign wd.enable     = wd_enable;
   assign wd.power_loss = power_loss;
   assign wd.retain     = ctrl_q[CTRL_RETAIN];
   assign wd.operand    = watch_op;
   assign wd.gain       = gain_q;
   assign wd.offset     = offset_q;
   assign wd.upper      = upper_q;
   assign wd.lower      = lower_q;

   acw_watch u_watch (
      .clk (clk),
      .rst (rst),
      .wd  (wd.watch)
   );

   // read port, data one cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (rd)
      begin
         case (addr)
            REG_CTRL:   rdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
            REG_GAIN:   rdata_q <= 32'(acw_wide_t'(gain_q));
            REG_OFFSET: rdata_q <= 32'(acw_wide_t'(offset_q));
            REG_ON:     rdata_q <= 32'(acw_wide_t'(on_q));
            REG_OFF:    rdata_q <= 32'(acw_wide_t'(off_q));
            REG_DEC:    rdata_q <= {30'h00000000, dec_q};
            REG_UPPER:  rdata_q <= 32'(acw_wide_t'(upper_q));
            REG_LOWER:  rdata_q <= 32'(acw_wide_t'(lower_q));
            REG_SRC:    rdata_q <= {{(32-SRC_W){1'b0}}, src_q};
            REG_DELAY:  rdata_q <= {16'h0000, delay_q};
            REG_SCAN:   rdata_q <= {16'h0000, scan_q};
            REG_STATUS: rdata_q <= {28'h0000000, wd.armed, wd.q, dly_q, cmp_q_q};
            REG_DIFF:   rdata_q <= 32'(diff_q);
            REG_REF:    rdata_q <= 32'(wd.ref_scaled);
            default:    rdata_q <= 32'h0000_0000;
         endcase
      end
      else
      begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign rdata         = rdata_q;
   assign scan_tick     = tick_q;
   assign cmp_q         = cmp_q_q;
   assign cmp_delayed_q = dly_q;
   assign wd_q          = wd.q;

endmodule

// >>> hw/acw_watch.sv
// deviation watchdog: reference capture and asymmetric band check
`timescale 1ns/10ps
module acw_watch (
   input wire logic clk,
   input wire logic rst,
   acw_wd_if.watch  wd
);
   import acw_pkg::*;

   acw_wd_state_t state_q;
   logic          en_q;
   acw_val_t      ref_q;
   logic          q_q;
   acw_wide_t     live;
   acw_wide_t     refv;
   logic          outside;

   // both live and captured value go through the same scaling
   always_comb
   begin
      live    = acw_scale(wd.operand, wd.gain, wd.offset);
      refv    = acw_scale(ref_q, wd.gain, wd.offset);
      outside = (live > refv + acw_wide_t'(wd.upper)) ||
                (live < refv - acw_wide_t'(wd.lower));
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= WD_IDLE;
         en_q    <= 1'b0;
         ref_q   <= 16'h0000;
         q_q     <= 1'b0;
      end
      else if (wd.power_loss && !wd.retain)
      begin
         state_q <= WD_IDLE;
         en_q    <= 1'b0;
         ref_q   <= 16'h0000;
         q_q     <= 1'b0;
      end
      else if (wd.scan)
      begin
         en_q <= wd.enable;
         case (state_q)
            WD_IDLE:
            begin
               q_q <= 1'b0;
               if (wd.enable && !en_q)
               begin
                  ref_q   <= wd.operand;
                  state_q <= WD_ARMED;
               end
            end
            WD_ARMED:
            begin
               if (!wd.enable)
               begin
                  q_q     <= 1'b0;
                  state_q <= WD_IDLE;
               end
               else
               begin
                  q_q <= outside;
               end
            end
            default:
            begin
               state_q <= WD_IDLE;
               q_q     <= 1'b0;
            end
         endcase
      end
   end

   assign wd.q          = q_q;
   assign wd.armed      = (state_q == WD_ARMED);
   assign wd.ref_scaled = refv;

endmodule

// >>> hw/acw_wd_if.sv
// link between the top and the deviation watchdog
`timescale 1ns/10ps
interface acw_wd_if;
   import acw_pkg::*;
   logic      scan;
   logic      enable;
   logic      power_loss;
   logic      retain;
   acw_val_t  operand;
   acw_val_t  gain;
   acw_val_t  offset;
   acw_val_t  upper;
   acw_val_t  lower;
   logic      q;
   logic      armed;
   acw_wide_t ref_scaled;

   modport watch (
      input  scan, enable, power_loss, retain, operand, gain, offset, upper, lower,
      output q, armed, ref_scaled
   );
   modport ctrl (
      output scan, enable, power_loss, retain, operand, gain, offset, upper, lower,
      input  q, armed, ref_scaled
   );
endinterface

// >>> test/acw_chk.sv
// port assertions for the compare and watchdog block
`timescale 1ns/10ps
module acw_chk
   import acw_pkg::*;
#(
   parameter int NBLK = 8
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        wd_enable,
   input wire logic        power_loss,
   input wire logic        scan_tick,
   input wire logic        cmp_q,
   input wire logic        cmp_delayed_q,
   input wire logic        wd_q
);
   logic [3:0] ctrl_q;
   // shadow of the control word
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_q <= 4'h0;
      end
      else if (wr && addr == REG_CTRL)
      begin
         ctrl_q <= wdata[3:0];
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside its slot");
   a_tick_pulse: assert property (scan_tick |=> !scan_tick)
      else $error("scan tick too long");
   a_cmp_on_tick: assert property ($changed(cmp_q) |-> $past(scan_tick))
      else $error("compare output moved off tick");
   a_wd_on_tick: assert property (
      $changed(wd_q) |-> $past(scan_tick) || $past(power_loss))
      else $error("watchdog output moved off tick");
   a_dly_needs_cmp: assert property (scan_tick && !cmp_q |=> !cmp_delayed_q)
      else $error("delayed output without compare");
   a_dly_copy: assert property (
      scan_tick && !ctrl_q[CTRL_DLY_EN] |=> cmp_delayed_q == $past(cmp_q))
      else $error("undelayed output not a copy");
   a_wd_off_drop: assert property (scan_tick && !wd_enable |=> !wd_q)
      else $error("watchdog set while disabled");
   a_wd_rise_en: assert property ($rose(wd_q) |-> $past(wd_enable))
      else $error("watchdog rose without enable");
   a_pwr_clear: assert property (
      power_loss && !ctrl_q[CTRL_RETAIN] |=> !wd_q)
      else $error("watchdog kept over power loss");
   c_cmp_set: cover property (scan_tick ##1 $rose(cmp_q));
   c_dly_set: cover property ($rose(cmp_delayed_q));
   c_wd_set: cover property ($rose(wd_q));
   c_pwr_loss: cover property (power_loss && wd_q);
endmodule

bind acw_top acw_chk #(.NBLK(NBLK)) u_acw_chk (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .wd_enable(wd_enable), .power_loss(power_loss), .scan_tick(scan_tick),
   .cmp_q(cmp_q), .cmp_delayed_q(cmp_delayed_q), .wd_q(wd_q)
);

// >>> test/acw_src_model.sv
// operand sources standing beside the compare and watchdog block
`timescale 1ns/10ps
module acw_src_model
   import acw_pkg::*;
#(
   parameter int NBLK = 8
) (
   output logic [9:0]        analog_input_source,
   output acw_pkg::acw_val_t analog_flag_source,
   output acw_pkg::acw_val_t analog_output_source,
   output acw_pkg::acw_val_t block_value [NBLK]
);
   // levels change just after a clock edge
   task automatic put(input int kind, input int idx, input acw_val_t v);
      case (kind)
         0: analog_input_source <= v[9:0];
         1: analog_flag_source <= v;
         2: analog_output_source <= v;
         default: block_value[idx] <= v;
      endcase
   endtask
   initial
   begin
      analog_input_source = 10'h000;
      analog_flag_source = 16'h0000;
      analog_output_source = 16'h0000;
      for (int i = 0; i < NBLK; i++)
         block_value[i] = 16'h0000;
   end
endmodule

// >>> test/tb.sv
// self-checking bench for the compare and watchdog block
`timescale 1ns/10ps
module tb;
   import acw_pkg::*;
   localparam int NBLK = 8;
   logic        clk, rst, wr, rd, rd_q, wd_enable, power_loss;
   logic        scan_tick, cmp_q, cmp_delayed_q, wd_q;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [31:0] seed = 32'h0000_004C;
   logic [9:0]  ain;
   acw_val_t    aflag, aout;
   acw_val_t    blk [NBLK];
   logic [63:0] exp_q [$];
   int          bad_count = 0;
   int          checks = 0;
   logic [5:0]  pin_q [$];
   logic        tk_q;
   int          hx [7] = '{50, 101, 50, 20, 21, 100, 101};
   int          wx [4] = '{19, 20, 99, 100};
   logic [6:0]  hq = 7'b1000110;
   logic [3:0]  wq = 4'b0110;

   acw_src_model #(.NBLK(NBLK)) u_acw_src_model (.analog_input_source(ain),
      .analog_flag_source(aflag), .analog_output_source(aout), .block_value(blk));
   acw_top #(.NBLK(NBLK)) u_acw_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .analog_input_source(ain), .analog_flag_source(aflag),
      .analog_output_source(aout), .block_value(blk), .wd_enable(wd_enable),
      .power_loss(power_loss), .scan_tick(scan_tick), .cmp_q(cmp_q),
      .cmp_delayed_q(cmp_delayed_q), .wd_q(wd_q));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic tally_and_finish();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back({e & m, m});
      @(posedge clk);
      rd <= 1'b0;
   endtask

   task automatic cmp_word(input logic [63:0] n);
      checks = checks + 1;
      if ((rdata & n[31:0]) !== n[63:32])
      begin
         bad_count = bad_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata & n[31:0], n[63:32]);
      end
   endtask

   task automatic cmp_pins(input logic [5:0] n);
      logic [2:0] g;
      g = {wd_q, cmp_delayed_q, cmp_q} & n[2:0];
      checks = checks + 1;
      if (g !== n[5:3])
      begin
         bad_count = bad_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, n[5:3]);
      end
   endtask

   // waits for the next scan tick and lets its edge land
   task automatic tick();
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n = n + 1;
      end
      while (scan_tick !== 1'b1 && n < 1100);
      if (n >= 1100)
      begin
         bad_count = bad_count + 1;
         tally_and_finish();
      end
      else
      begin
         @(posedge clk);
      end
   endtask

   task automatic ev(input int x, input logic [31:0] e, input logic [31:0] m);
      u_acw_src_model.put(0, 0, acw_val_t'(x));
      tick();
      pin_q.push_back({e[2:0] & m[2:0], m[2:0]});
      rd_chk(REG_STATUS, e, m);
   endtask

   task automatic pulse_loss();
      @(posedge clk);
      power_loss <= 1'b1;
      @(posedge clk);
      power_loss <= 1'b0;
   endtask

   always @(posedge clk)
   begin
      rd_q <= rd;
      tk_q <= scan_tick;
   end

   // read data stands in the cycle after the strobe
   always @(negedge clk)
   begin
      if (rd_q === 1'b1 && exp_q.size() > 0)
      begin
         cmp_word(exp_q.pop_front());
      end
      if (tk_q === 1'b1 && pin_q.size() > 0)
      begin
         cmp_pins(pin_q.pop_front());
      end
   end

   initial
   begin
      int x;
      int y;
      rst = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      rd_q = 1'b0;
      tk_q = 1'b0;
      wd_enable = 1'b0;
      power_loss = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd_chk(REG_GAIN, 32'h0000_0064, '1);
      rd_chk(REG_SCAN, 32'h0000_03E8, '1);
      rd_chk(8'h3C, 32'h0, '1);
      wr_reg(REG_SCAN, 32'h0000_0008);
      wr_reg(REG_GAIN, 32'h0000_1388);
      rd_chk(REG_GAIN, 32'h0000_03E8, '1);
      wr_reg(REG_OFFSET, 32'hFFFF_B1E0);
      rd_chk(REG_OFFSET, 32'hFFFF_D8F0, '1);
      wr_reg(REG_ON, 32'h0000_7530);
      rd_chk(REG_ON, 32'h0000_4E20, '1);
      wr_reg(REG_OFF, 32'hFFFF_8AD0);
      rd_chk(REG_OFF, 32'hFFFF_B1E0, '1);
      wr_reg(REG_LOWER, 32'hFFFF_FFFB);
      rd_chk(REG_LOWER, 32'h0, '1);
      wr_reg(REG_DEC, 32'h3);
      rd_chk(REG_DEC, 32'h3, 32'h3);
      $display("test registers done");
      wr_reg(REG_GAIN, 32'h0000_00FA);
      wr_reg(REG_OFFSET, 32'hFFFF_FED4);
      wr_reg(REG_SRC, 32'h0020_0004);
      for (int i = 0; i < 6; i++)
      begin
         x = (i == 0) ? 1023 : int'(rnd() % 32'd1024);
         y = int'(rnd() % 32'd2001) - 1000;
         u_acw_src_model.put(0, 0, acw_val_t'(x));
         u_acw_src_model.put(1, 0, acw_val_t'(y));
         tick();
         rd_chk(REG_DIFF, 32'((x > 1000 ? 1000 : x) * 250 / 100 - y * 250 / 100), '1);
      end
      $display("test scaling done");
      u_acw_src_model.put(0, 0, acw_val_t'(0));
      u_acw_src_model.put(1, 0, acw_val_t'(0));
      wr_reg(REG_GAIN, 32'h0000_0064);
      wr_reg(REG_ON, 32'h0000_0064);
      wr_reg(REG_OFF, 32'h0000_0014);
      for (int i = 0; i < 7; i++)
         ev(hx[i], {31'h0, hq[i]}, 32'h1);
      wr_reg(REG_ON, 32'h0000_0014);
      wr_reg(REG_OFF, 32'h0000_0064);
      for (int i = 0; i < 4; i++)
         ev(wx[i], {31'h0, wq[i]}, 32'h1);
      wr_reg(REG_OFF, 32'h0000_0014);
      wr_reg(REG_CTRL, 32'h1);
      u_acw_src_model.put(3, 2, acw_val_t'(60));
      ev(59, 32'h0, 32'h1);
      ev(61, 32'h1, 32'h1);
      $display("test thresholds done");
      wr_reg(REG_CTRL, 32'h8);
      wr_reg(REG_DELAY, 32'h2);
      ev(0, 32'h0, 32'h1);
      ev(30, 32'h1, 32'h3);
      ev(0, 32'h0, 32'h3);
      ev(30, 32'h1, 32'h3);
      ev(30, 32'h1, 32'h3);
      ev(30, 32'h1, 32'h3);
      ev(30, 32'h3, 32'h3);
      ev(30, 32'h3, 32'h3);
      $display("test delay done");
      wr_reg(REG_CTRL, 32'h0);
      wr_reg(REG_UPPER, 32'h0000_0032);
      wr_reg(REG_LOWER, 32'h0000_001E);
      wd_enable <= 1'b1;
      ev(500, 32'h8, 32'hC);
      rd_chk(REG_REF, 32'h0000_00C8, '1);
      ev(551, 32'hC, 32'hC);
      ev(550, 32'h8, 32'hC);
      ev(470, 32'h8, 32'hC);
      ev(469, 32'hC, 32'hC);
      wr_reg(REG_GAIN, 32'h0000_00C8);
      rd_chk(REG_REF, 32'h0000_02BC, '1);
      ev(500, 32'h8, 32'hC);
      ev(526, 32'hC, 32'hC);
      wd_enable <= 1'b0;
      ev(526, 32'h0, 32'h4);
      wr_reg(REG_CTRL, 32'h4);
      wd_enable <= 1'b1;
      ev(500, 32'h8, 32'hC);
      ev(600, 32'hC, 32'hC);
      pulse_loss();
      rd_chk(REG_STATUS, 32'hC, 32'hC);
      wr_reg(REG_CTRL, 32'h0);
      ev(600, 32'hC, 32'hC);
      pulse_loss();
      rd_chk(REG_STATUS, 32'h0, 32'hC);
      $display("test watchdog done");
      tally_and_finish();
   end
endmodule
